//--- cbri_pkg.sv
`default_nettype none
package cbri_pkg;
    // machine cycle is eight clock pulses
    localparam int CYCLE_PULSES = 8;
    localparam logic [2:0] PULSE_LAST = 3'h7;
    // ram select sampled at start of pulse 7 of the cycle (clock 70)
    localparam logic [2:0] SEL_SAMPLE_PULSE = 3'h7;
    // clock pulse 3 of next cycle (clock 31): ram drive must be off by then
    localparam logic [2:0] DRIVE_CUTOFF_PULSE = 3'h3;
    // external memory access window, in half pulses (4.5 pulses)
    localparam int ACCESS_HALF_PULSES = 9;
    // read window pulse 2 to pulse 6; the registered read level is low from pulse 3 to pulse 7, five pulses of access
    localparam logic [2:0] READ_START_PULSE = 3'h2;
    localparam logic [2:0] READ_END_PULSE = 3'h6;
    // output flag updated at pulse 4 instead of the older pulse 5
    localparam logic [2:0] FLAG_UPDATE_PULSE = 3'h4;
    localparam logic [2:0] WRITE_PULSE = 3'h5;
    localparam int RAM_DEPTH = 64;
    localparam int RAM_AW = 6;
    localparam int DATA_W = 8;
    // apb register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_COUNT = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_OPCODE = 12'h00C;
    localparam logic [11:0] ADDR_MEMADDR = 12'h010;
    // ctrl fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_TOGGLE_BIT = 1;
    localparam int CTRL_MEMWR_BIT = 2;
    localparam int CTRL_LOAD_BIT = 3;
    localparam int CTRL_IRQ_CLR_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] OPCODE_RESET = 8'hC4;
    // opcode nibbles of the i/o, flag, long and extended instruction groups
    localparam logic [3:0] IO_GROUP = 4'h6;
    localparam logic [3:0] SEQ_OPCODE_LO = 4'hB;
    localparam logic [3:0] REQ_OPCODE_LO = 4'hA;
    localparam logic [3:0] MISC_GROUP = 4'h7;
    localparam logic [3:0] LONG_GROUP = 4'hC;
    localparam logic [3:0] EXT_GROUP = 4'h6;
    localparam logic [3:0] EXT_NIBBLE = 4'h8;
    typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_EXEC2} cbri_state_t;
endpackage
`default_nettype wire

//--- cbri_core.sv
// Chosen here: the address map and the APB interface to the registers.
`default_nettype none
// Behaviour
// - full variant holds a 64 byte ram reachable over the data bus
// - software presettable 8 bit down counter
// - counter underflow raises interrupt and may toggle the output flag
// - reduced variant has no ram; its select pin is tied high
// - external memory gets 4.5 clock pulses per machine cycle to access; the read level here is low five pulses (3 to 7)
// - set and clear output bit update the flag one clock pulse early
// - external flags are sampled at end of the fetch cycle
// - two machine cycles per instruction; long and extended ones take more
// - ram select sampled at start of pulse 7; decoder holds it stable
// - ram read data driven from the sample pulse until pulse 3 of the next cycle, or earlier if ram select drops
// - 8 bit bidirectional data bus carries all transfers
// - io command lines low except during io instruction, then opcode bits
// - fourth opcode bit sets direction shown on the read level
// - each machine cycle is eight clock pulses
module cbri_core #(
    parameter bit HAS_RAM = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ram_select_n,
    input wire logic clear_n,
    input wire logic wait_n,
    input wire logic external_flag_one,
    input wire logic external_flag_two,
    input wire logic [cbri_pkg::DATA_W-1:0] data_bus_lines_in,
    output logic [cbri_pkg::DATA_W-1:0] data_bus_lines_out,
    output logic data_bus_lines_oe_n,
    output logic read_level_n,
    output logic write_pulse_n,
    output logic [2:0] io_command_lines,
    output logic output_flag,
    output logic counter_irq,
    output logic fetch_state,
    output logic [2:0] pulse_index
);
    import cbri_pkg::*;

    logic [1:0] sel_sync_q, clr_sync_q, wait_sync_q, ef1_sync_q, ef2_sync_q;
    logic [DATA_W-1:0] bus_sync0_q, bus_sync1_q;
    logic [2:0] pulse_q;
    cbri_state_t state_q, state_d;
    logic [7:0] ctrl_q, count_q, opcode_q;
    logic [15:0] memaddr_q;
    logic [1:0] flags_q;
    logic irq_q, flag_q, toggle_q, sel_act_q, drive_q;
    logic [DATA_W-1:0] ram_q [RAM_DEPTH];
    logic [DATA_W-1:0] dout_q;
    logic [1:0] ef_prev_q;

    wire sel_n_s = sel_sync_q[1];
    wire run_mode = clr_sync_q[1] && wait_sync_q[1];
    wire reset_mode = !clr_sync_q[1] && wait_sync_q[1];
    wire cycle_end = run_mode && (pulse_q == PULSE_LAST);
    wire [3:0] op_hi = opcode_q[7:4];
    wire [3:0] op_lo = opcode_q[3:0];
    wire io_instr = (op_hi == IO_GROUP) && (op_lo != 4'h0) && (op_lo != EXT_NIBBLE);
    wire io_exec = io_instr && (state_q != ST_FETCH);
    wire is_seq = (op_hi == MISC_GROUP) && (op_lo == SEQ_OPCODE_LO);
    wire is_req = (op_hi == MISC_GROUP) && (op_lo == REQ_OPCODE_LO);
    wire long_instr = (op_hi == LONG_GROUP) || ((op_hi == EXT_GROUP) && (op_lo == EXT_NIBBLE));
    wire mem_write = ctrl_q[CTRL_MEMWR_BIT] || (io_exec && !opcode_q[3]);
    wire read_window = (pulse_q >= READ_START_PULSE) && (pulse_q <= READ_END_PULSE);
    wire [RAM_AW-1:0] ram_index = memaddr_q[RAM_AW-1:0];
    wire ef_edge = ef1_sync_q[1] && !ef_prev_q[0];
    wire underflow_tick = run_mode && cycle_end && (state_q == ST_EXEC) && (count_q == 8'h01);

    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_count = paddr == ADDR_COUNT;
    wire hit_status = paddr == ADDR_STATUS;
    wire hit_opcode = paddr == ADDR_OPCODE;
    wire hit_memaddr = paddr == ADDR_MEMADDR;
    wire hit_any = hit_ctrl || hit_count || hit_status || hit_opcode || hit_memaddr;
    wire load_cnt = apb_wr && hit_count;
    wire irq_clr = apb_wr && hit_ctrl && pwdata[CTRL_IRQ_CLR_BIT];
    wire [31:0] status_word = {23'h0, state_q, flags_q, toggle_q, flag_q, irq_q, sel_act_q, HAS_RAM};

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = !(psel && penable) ? 32'h0 :
        hit_ctrl ? {24'h0, ctrl_q} :
        hit_count ? {24'h0, count_q} :
        hit_status ? status_word :
        hit_opcode ? {24'h0, opcode_q} :
        hit_memaddr ? {16'h0, memaddr_q} : 32'h0;

    // synchronisers for the mode and select pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_sync_q <= 2'h3;
            clr_sync_q <= 2'h3;
            wait_sync_q <= 2'h3;
        end
        else
        begin
            // reduced variant sees its select as tied high
            sel_sync_q <= {sel_sync_q[0], ram_select_n || !HAS_RAM};
            clr_sync_q <= {clr_sync_q[0], clear_n};
            wait_sync_q <= {wait_sync_q[0], wait_n};
        end
    end

    // synchronisers for the flag and data pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ef1_sync_q <= 2'h0;
            ef2_sync_q <= 2'h0;
            bus_sync0_q <= 8'h00;
            bus_sync1_q <= 8'h00;
        end
        else
        begin
            ef1_sync_q <= {ef1_sync_q[0], external_flag_one};
            ef2_sync_q <= {ef2_sync_q[0], external_flag_two};
            bus_sync0_q <= data_bus_lines_in;
            bus_sync1_q <= bus_sync0_q;
        end
    end

    // pulse counter: eight pulses per machine cycle, held in pause
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_q <= 3'h0;
        else if (reset_mode)
            pulse_q <= 3'h0;
        else if (run_mode)
            pulse_q <= pulse_q + 3'h1;
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_FETCH: state_d = ST_EXEC;
            ST_EXEC: state_d = long_instr ? ST_EXEC2 : ST_FETCH;
            ST_EXEC2: state_d = ST_FETCH;
            default: state_d = ST_FETCH;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_FETCH;
        else if (reset_mode)
            state_q <= ST_FETCH;
        else if (cycle_end)
            state_q <= state_d;
    end

    // flags taken at the last pulse of the fetch cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= 2'h0;
        else if (cycle_end && state_q == ST_FETCH)
            flags_q <= {ef2_sync_q[1], ef1_sync_q[1]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= CTRL_RESET;
        else if (apb_wr && hit_ctrl)
            ctrl_q <= {3'h0, 1'b0, pwdata[3:0]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opcode_q <= OPCODE_RESET;
        else if (apb_wr && hit_opcode)
            opcode_q <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            memaddr_q <= 16'h0000;
        else if (apb_wr && hit_memaddr)
            memaddr_q <= pwdata[15:0];
    end

    // down counter: decrements per execute cycle, or on flag-one rising edges when run bit clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= COUNT_RESET;
            ef_prev_q <= 2'h0;
        end
        else
        begin
            ef_prev_q <= {ef_prev_q[0], ef1_sync_q[1]};
            if (load_cnt)
                count_q <= pwdata[7:0];
            else if (ctrl_q[CTRL_RUN_BIT] ? (cycle_end && state_q == ST_EXEC) : ef_edge)
                count_q <= count_q - 8'h01;
        end
    end

    wire cnt_under = load_cnt ? 1'b0 : (ctrl_q[CTRL_RUN_BIT] ? underflow_tick : (ef_edge && count_q == 8'h01));

    // underflow and software clear in one cycle: the set wins
    wire irq_set = cnt_under;
    wire toggle_clr = load_cnt || reset_mode;
    wire toggle_wr = apb_wr && hit_ctrl;
    wire flag_slot = run_mode && state_q == ST_EXEC && pulse_q == FLAG_UPDATE_PULSE;
    wire flag_prog = flag_slot && (is_seq || is_req);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else if (irq_set)
            irq_q <= 1'b1;
        else if (irq_clr)
            irq_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            toggle_q <= 1'b0;
        else if (toggle_clr)
            toggle_q <= 1'b0;
        else if (toggle_wr)
            toggle_q <= pwdata[CTRL_TOGGLE_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= 1'b0;
        else if (reset_mode)
            flag_q <= 1'b0;
        else if (toggle_q && irq_set)
            flag_q <= !flag_q;
        else if (flag_prog)
            flag_q <= is_seq;
    end

    // drive starts only at the sample pulse, so a select held over several cycles
    // cannot restart it after the cutoff
    wire sample_now = run_mode && pulse_q == SEL_SAMPLE_PULSE;
    wire drive_stop = sel_n_s || mem_write || pulse_q == DRIVE_CUTOFF_PULSE;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sel_act_q <= 1'b0;
        else if (sample_now)
            sel_act_q <= !sel_n_s;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive_q <= 1'b0;
        else if (sample_now)
            drive_q <= !sel_n_s && !mem_write;
        else if (drive_stop)
            drive_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dout_q <= 8'h00;
        else if (sample_now && !sel_n_s)
            dout_q <= ram_q[ram_index];
    end

    // ram writes at the last pulse of the cycle when selected
    always_ff @(posedge pclk)
    begin
        if (HAS_RAM && sel_act_q && mem_write && run_mode && pulse_q == PULSE_LAST && !sel_n_s)
            ram_q[ram_index] <= bus_sync1_q;
    end

    wire rd_cycle = run_mode && !mem_write && read_window;
    wire wr_strobe = run_mode && mem_write && pulse_q == WRITE_PULSE;
    wire [2:0] io_cmd_d = (io_exec && run_mode) ? opcode_q[2:0] : 3'h0;

    // on i/o instructions the read level shows the transfer direction instead
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            read_level_n <= 1'b1;
        else if (io_exec)
            read_level_n <= !opcode_q[3];
        else
            read_level_n <= !rd_cycle;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            write_pulse_n <= 1'b1;
        else
            write_pulse_n <= !wr_strobe;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            io_command_lines <= 3'h0;
        else
            io_command_lines <= io_cmd_d;
    end

    // bus released unless ram data is sampled active
    assign data_bus_lines_oe_n = !(HAS_RAM && drive_q);
    assign data_bus_lines_out = dout_q;
    assign output_flag = flag_q;
    assign counter_irq = irq_q;
    assign fetch_state = state_q == ST_FETCH;
    assign pulse_index = pulse_q;
endmodule
`default_nettype wire

//--- cbri_core_sva.sv
`default_nettype none
module cbri_core_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic data_bus_lines_oe_n,
    input wire logic write_pulse_n,
    input wire logic [2:0] io_command_lines,
    input wire logic output_flag,
    input wire logic counter_irq,
    input wire logic fetch_state,
    input wire logic [2:0] pulse_index
);
    import cbri_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pulse_step: assert property ($changed(pulse_index) |->
        pulse_index == $past(pulse_index) + 3'h1 || pulse_index == 3'h0) else $error("pulse index skipped");
    chk_state_edge: assert property ($changed(fetch_state) |->
        pulse_index == 3'h0 && ($past(pulse_index) != 3'h0 || fetch_state)) else $error("state moved mid cycle");
    chk_io_idle: assert property (fetch_state && pulse_index != 3'h0 |-> io_command_lines == 3'h0)
        else $error("io lines active in fetch");
    chk_drive_start: assert property ($fell(data_bus_lines_oe_n) |-> $past(pulse_index) == SEL_SAMPLE_PULSE)
        else $error("bus drive began off the sample pulse");
    chk_drive_cutoff: assert property (pulse_index == 3'h4 |-> data_bus_lines_oe_n)
        else $error("bus still driven past cutoff");
    chk_write_time: assert property ($fell(write_pulse_n) |-> $past(pulse_index) == WRITE_PULSE)
        else $error("write pulse misplaced");
    chk_no_drive_wr: assert property (!write_pulse_n |-> data_bus_lines_oe_n)
        else $error("bus driven during write");
    chk_flag_time: assert property ($changed(output_flag) && $past(pulse_index) != FLAG_UPDATE_PULSE |->
        counter_irq || !output_flag) else $error("flag moved off its pulse");
    chk_err_unmapped: assert property (psel && penable && paddr > ADDR_MEMADDR |-> pslverr)
        else $error("unmapped access not refused");
    chk_rdata_idle: assert property (!penable |-> prdata == 32'h0)
        else $error("read data outside access");
endmodule
bind cbri_core cbri_core_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr,
    .data_bus_lines_oe_n, .write_pulse_n, .io_command_lines, .output_flag, .counter_irq, .fetch_state, .pulse_index);
`default_nettype wire

//--- cbri_ext_mem.sv
`default_nettype none
module cbri_ext_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] pulse_index,
    input wire logic sel_req,
    input wire logic [cbri_pkg::DATA_W-1:0] wr_byte,
    input wire logic [cbri_pkg::DATA_W-1:0] dut_out,
    input wire logic dut_oe_n,
    output var logic ram_select_n,
    output logic [cbri_pkg::DATA_W-1:0] bus
);
    import cbri_pkg::*;
    logic [DATA_W-1:0] last_q = 8'h00;
    // decoded select moves only at pulse 1: stable at the sample, gone before pulse 3
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ram_select_n <= 1'b1;
        else if (pulse_index == 3'h1)
            ram_select_n <= !sel_req;
    // undriven bus shows a changing pattern, never the last value
    always_comb
        if (!dut_oe_n)
            bus = dut_out;
        else if (!ram_select_n)
            bus = wr_byte;
        else
            bus = ~last_q;
    always_ff @(posedge pclk)
        last_q <= bus;
endmodule
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cbri_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, e, oe_n, rl_n, wp_n, flag, irq, fst, ram_sel_n;
    logic clear_n = 1, wait_n = 1, ef1 = 0, ef2 = 0, sel_req = 0;
    logic [7:0] wr_byte = 8'h00, bus, dout, op;
    logic [2:0] io, pidx, p;
    int error_cnt = 0, total_checks = 0, cyc = 0, n;
    cbri_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ram_select_n(ram_sel_n), .clear_n, .wait_n, .external_flag_one(ef1), .external_flag_two(ef2),
        .data_bus_lines_in(bus), .data_bus_lines_out(dout), .data_bus_lines_oe_n(oe_n), .read_level_n(rl_n),
        .write_pulse_n(wp_n), .io_command_lines(io), .output_flag(flag), .counter_irq(irq),
        .fetch_state(fst), .pulse_index(pidx));
    cbri_ext_mem ext (.pclk, .presetn, .pulse_index(pidx), .sel_req, .wr_byte, .dut_out(dout),
        .dut_oe_n(oe_n), .ram_select_n(ram_sel_n), .bus);
    initial forever #5 pclk = ~pclk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && k++ < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_at(input logic f, input logic [2:0] q);
        int k;
        k = 0;
        do
        begin
            @(posedge pclk);
            #1;
        end
        while ((fst !== f || pidx !== q) && k++ < 64);
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk("oe_n", 1, oe_n);
        chk("io", 0, io);
        chk("fetch", 1, fst);
        apb(0, ADDR_OPCODE, 0);
        chk("opcode", {24'h0, OPCODE_RESET}, r & 32'hFF);
        apb(0, 12'h0F0, 0);
        chk("slverr", 1, e);
        chk("unmapped", 0, r);
        apb(1, ADDR_OPCODE, 32'h7A);
        apb(1, ADDR_MEMADDR, 32'h25);
        wr_byte <= 8'hA5;
        sel_req <= 1'b1;
        apb(1, ADDR_CTRL, 32'h4);
        repeat (40) @(posedge pclk);
        apb(1, ADDR_CTRL, 0);
        apb(1, ADDR_MEMADDR, 32'h65);
        repeat (16) @(posedge pclk);
        wait_at(0, 3'h1);
        chk("ram drive", 0, oe_n);
        chk("ram data", 32'hA5, dout);
        sel_req <= 1'b0;
        repeat (24) @(posedge pclk);
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            chk("no drive", 1, oe_n);
        end
        for (n = 0; n < 2; n++)
        begin
            op = n ? 8'h6D : 8'h65;
            apb(1, ADDR_OPCODE, {24'h0, op});
            wait_at(1, 3'h4);
            chk("io fetch", 0, io);
            wait_at(0, 3'h4);
            chk("io exec", op[2:0], io);
            chk("direction", !op[3], rl_n);
        end
        apb(1, ADDR_COUNT, 32'h2);
        apb(1, ADDR_CTRL, 32'h3);
        n = 0;
        while (irq !== 1'b1 && n++ < 200) @(posedge pclk);
        chk("irq", 1, irq);
        @(posedge pclk);
        chk("toggle", 1, flag);
        apb(1, ADDR_CTRL, 32'h10);
        @(posedge pclk);
        chk("irq clr", 0, irq);
        for (n = 0; n < 2; n++)
        begin
            apb(1, ADDR_OPCODE, n ? 32'h7B : 32'h7A);
            wait_at(0, 3'h3);
            chk("flag old", n ? 0 : 1, flag);
            wait_at(0, 3'h6);
            chk("flag new", n, flag);
        end
        ef1 <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(0, ADDR_STATUS, 0);
        chk("status", 32'h21, r & 32'h61);
        wait_n <= 1'b0;
        repeat (4) @(posedge pclk);
        p = pidx;
        repeat (8) @(posedge pclk);
        chk("pause", p, pidx);
        wait_n <= 1'b1;
        clear_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("clear pulse", 0, pidx);
        chk("clear flag", 0, flag);
        clear_n <= 1'b1;
        repeat (4) @(posedge pclk);
        end_of_test();
    end
endmodule
`default_nettype wire
